// [inc/asmc_map.svh]
`ifndef ASMC_MAP_SVH
`define ASMC_MAP_SVH

// timing figures in ns, slow grade by default
`define ASMC_CLK_PERIOD_NS 8
`define ASMC_T_ADDR_SETUP_START_NS 0
`define ASMC_T_ADDR_HOLD_END_NS 0
`define ASMC_T_CS_TO_END_NS 60
`define ASMC_T_BYTE_TO_END_NS 60
`define ASMC_T_DATA_SETUP_NS 30
`define ASMC_T_DATA_HOLD_NS 0
`define ASMC_T_ADDR_ACCESS_NS 70
`define ASMC_T_OE_ACCESS_NS 35
`define ASMC_T_OE_HIGHZ_NS 25
`define ASMC_T_POWER_DOWN_NS 70
`define ASMC_T_RETENTION_ENTRY_NS 0

// least times round up, at least one cycle
`define ASMC_CYC_UP(t) \
  ((((t) + `ASMC_CLK_PERIOD_NS - 1) / `ASMC_CLK_PERIOD_NS) < 1 ? 1 : \
   (((t) + `ASMC_CLK_PERIOD_NS - 1) / `ASMC_CLK_PERIOD_NS))

`define ASMC_WR_STROBE_CYC `ASMC_CYC_UP(`ASMC_T_BYTE_TO_END_NS)
`define ASMC_WR_DATA_CYC `ASMC_CYC_UP(`ASMC_T_DATA_SETUP_NS)
`define ASMC_RD_ACCESS_CYC `ASMC_CYC_UP(`ASMC_T_ADDR_ACCESS_NS + 8)
`define ASMC_TURN_CYC `ASMC_CYC_UP(`ASMC_T_OE_HIGHZ_NS)
`define ASMC_PD_CYC `ASMC_CYC_UP(`ASMC_T_POWER_DOWN_NS)
`define ASMC_RET_CYC `ASMC_CYC_UP(`ASMC_T_RETENTION_ENTRY_NS)

`define ASMC_ADDR_W 17
`define ASMC_DATA_W 16
`define ASMC_CNT_W 5
`define ASMC_CNT_ZERO 5'h00

`endif

// [inc/asmc_pkg.sv]
`default_nettype none
package asmc_pkg;
  `include "asmc_map.svh"
  typedef enum logic [2:0] {
    ASMC_IDLE,
    ASMC_WRITE,
    ASMC_READ,
    ASMC_TURN,
    ASMC_PDOWN,
    ASMC_RETAIN
  } asmc_state_t;
  typedef logic [`ASMC_ADDR_W-1:0] asmc_addr_t;
  typedef logic [`ASMC_DATA_W-1:0] asmc_data_t;
endpackage
`default_nettype wire

// [hdl/asmc_lane_io.sv]
`timescale 1ns/1ps
`default_nettype none
`include "asmc_map.svh"
// per byte lane: register drive enable and capture read data
module asmc_lane_io (
  input wire logic clk_sys_in,            // system clock
  input wire logic sys_rst_in,            // sync reset
  input wire logic [1:0] drive_in,        // lane drive request
  input wire logic [1:0] capture_in,      // lane capture strobe
  input wire logic [15:0] pin_sync_in,    // synchronised data pins
  output logic [1:0] drive_oe_out,        // registered lane enables
  output logic [15:0] cap_data_out        // captured read data
);
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_lane
      logic oe_ff;
      logic nxt_oe;
      logic [7:0] cap_ff;
      logic [7:0] nxt_cap;
      always_comb begin
        nxt_oe = drive_in[g];
        nxt_cap = capture_in[g] ? pin_sync_in[8*g +: 8] : cap_ff;
      end
      always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
          oe_ff <= 1'b0;
          cap_ff <= 8'h00;
        end else begin
          oe_ff <= nxt_oe;
          cap_ff <= nxt_cap;
        end
      end
      assign drive_oe_out[g] = oe_ff;
      assign cap_data_out[8*g +: 8] = cap_ff;
    end
  endgenerate
endmodule
`default_nettype wire

// [hdl/asmc_host.sv]
`timescale 1ns/1ps
`default_nettype none
`include "asmc_map.svh"
module asmc_host (
  input wire logic clk_sys_in,                 // 125 MHz clock
  input wire logic sys_rst_in,                 // sync reset, high
  input wire logic req_valid_in,               // request strobe
  input wire logic req_write_in,               // 1 write, 0 read
  input wire asmc_pkg::asmc_addr_t req_addr_in, // word address
  input wire asmc_pkg::asmc_data_t req_wdata_in, // write data
  input wire logic [1:0] req_bytes_in,         // lane enables, bit1 upper
  input wire logic retain_req_in,              // ask for retention
  output logic req_ready_out,                  // request accepted
  output logic rsp_valid_out,                  // read data valid pulse
  output asmc_pkg::asmc_data_t rsp_rdata_out,  // read data
  output logic retain_ok_out,                  // safe to drop supply
  output asmc_pkg::asmc_addr_t mem_addr_out,   // address pins
  output logic chip_sel_n_out,                 // chip select, low
  output logic write_strobe_n_out,             // write strobe, low
  output logic out_drive_n_out,                // output drive, low
  output logic upper_byte_sel_n_out,           // upper byte select
  output logic lower_byte_sel_n_out,           // lower byte select
  input wire asmc_pkg::asmc_data_t mem_data_in, // data pins, input
  output asmc_pkg::asmc_data_t mem_data_out,   // data pins, output
  output logic [15:0] mem_data_oe_out          // per-bit drive enable
);
  import asmc_pkg::*;

  asmc_state_t state_ff, nxt_state;
  logic [`ASMC_CNT_W-1:0] cnt_ff, nxt_cnt;
  asmc_addr_t addr_ff, nxt_addr;
  asmc_data_t wdata_ff, nxt_wdata;
  logic [1:0] bytes_ff, nxt_bytes;
  logic cs_n_ff, nxt_cs_n;
  logic we_n_ff, nxt_we_n;
  logic oe_n_ff, nxt_oe_n;
  logic rsp_ff, nxt_rsp;
  logic ret_ff, nxt_ret;
  asmc_data_t sync1_ff, sync2_ff;
  logic [1:0] lane_drive, lane_cap, lane_oe;
  asmc_data_t cap_data;
  logic accept;

  ////////////////////////////////////////////////////////////////////////////
  // pin input synchroniser; second stage is the only reader of the first
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      sync1_ff <= 16'h0000;
      sync2_ff <= 16'h0000;
    end else begin
      sync1_ff <= mem_data_in;
      sync2_ff <= sync1_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign accept = req_valid_in && (state_ff == ASMC_IDLE) && !retain_req_in;
  assign req_ready_out = (state_ff == ASMC_IDLE) && !retain_req_in;

  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_addr = addr_ff;
    nxt_wdata = wdata_ff;
    nxt_bytes = bytes_ff;
    nxt_cs_n = cs_n_ff;
    nxt_we_n = we_n_ff;
    nxt_oe_n = oe_n_ff;
    nxt_rsp = 1'b0;
    nxt_ret = ret_ff;
    lane_drive = 2'b00;
    lane_cap = 2'b00;
    case (state_ff)
      ASMC_IDLE: begin
        nxt_oe_n = 1'b1;
        nxt_we_n = 1'b1;
        if (retain_req_in) begin
          nxt_cs_n = 1'b1;
          nxt_bytes = 2'b00;
          nxt_cnt = `ASMC_CNT_W'(`ASMC_RET_CYC);
          nxt_state = ASMC_RETAIN;
        end else if (accept && req_bytes_in != 2'b00) begin
          // address, select, bytes and write strobe move together
          nxt_addr = req_addr_in;
          nxt_bytes = req_bytes_in;
          nxt_cs_n = 1'b0;
          nxt_wdata = req_wdata_in;
          if (req_write_in) begin
            // lanes drive with the strobe; memory output stays off
            lane_drive = req_bytes_in;
            nxt_we_n = 1'b0;
            nxt_cnt = `ASMC_CNT_W'(`ASMC_WR_STROBE_CYC);
            nxt_state = ASMC_WRITE;
          end else begin
            nxt_oe_n = 1'b0;
            nxt_cnt = `ASMC_CNT_W'(`ASMC_RD_ACCESS_CYC);
            nxt_state = ASMC_READ;
          end
        end
      end
      ASMC_WRITE: begin
        // output drive stays high, so the memory never drives here
        lane_drive = bytes_ff;
        if (cnt_ff == `ASMC_CNT_ZERO) begin
          // write strobe alone ends the write; data held one more cycle
          nxt_we_n = 1'b1;
          nxt_cnt = `ASMC_CNT_W'(`ASMC_PD_CYC);
          nxt_state = ASMC_PDOWN;
        end else begin
          nxt_cnt = cnt_ff - 1'b1;
        end
      end
      ASMC_READ: begin
        if (cnt_ff == `ASMC_CNT_ZERO) begin
          // extra cycles cover the two synchroniser stages
          lane_cap = bytes_ff;
          nxt_rsp = 1'b1;
          nxt_oe_n = 1'b1;
          nxt_cnt = `ASMC_CNT_W'(`ASMC_TURN_CYC);
          nxt_state = ASMC_TURN;
        end else begin
          nxt_cnt = cnt_ff - 1'b1;
        end
      end
      ASMC_TURN: begin
        // bus release time before any later write may drive
        if (cnt_ff == `ASMC_CNT_ZERO) begin
          nxt_cs_n = 1'b1;
          nxt_bytes = 2'b00;
          nxt_cnt = `ASMC_CNT_W'(`ASMC_PD_CYC);
          nxt_state = ASMC_PDOWN;
        end else begin
          nxt_cnt = cnt_ff - 1'b1;
        end
      end
      ASMC_PDOWN: begin
        nxt_cs_n = 1'b1;
        nxt_bytes = 2'b00;
        if (cnt_ff == `ASMC_CNT_ZERO) begin
          nxt_state = ASMC_IDLE;
        end else begin
          nxt_cnt = cnt_ff - 1'b1;
        end
      end
      ASMC_RETAIN: begin
        nxt_ret = (cnt_ff == `ASMC_CNT_ZERO);
        if (cnt_ff != `ASMC_CNT_ZERO) begin
          nxt_cnt = cnt_ff - 1'b1;
        end
        if (!retain_req_in) begin
          nxt_ret = 1'b0;
          nxt_cnt = `ASMC_CNT_W'(`ASMC_PD_CYC);
          nxt_state = ASMC_PDOWN;
        end
      end
      default: begin
        nxt_state = ASMC_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      state_ff <= ASMC_IDLE;
      cnt_ff <= `ASMC_CNT_ZERO;
      addr_ff <= 17'h00000;
      wdata_ff <= 16'h0000;
      bytes_ff <= 2'b00;
      cs_n_ff <= 1'b1;
      we_n_ff <= 1'b1;
      oe_n_ff <= 1'b1;
      rsp_ff <= 1'b0;
      ret_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      addr_ff <= nxt_addr;
      wdata_ff <= nxt_wdata;
      bytes_ff <= nxt_bytes;
      cs_n_ff <= nxt_cs_n;
      we_n_ff <= nxt_we_n;
      oe_n_ff <= nxt_oe_n;
      rsp_ff <= nxt_rsp;
      ret_ff <= nxt_ret;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  asmc_lane_io u_lane (
    .clk_sys_in(clk_sys_in),
    .sys_rst_in(sys_rst_in),
    .drive_in(lane_drive),
    .capture_in(lane_cap),
    .pin_sync_in(sync2_ff),
    .drive_oe_out(lane_oe),
    .cap_data_out(cap_data)
  );

  assign mem_addr_out = addr_ff;
  assign chip_sel_n_out = cs_n_ff;
  assign write_strobe_n_out = we_n_ff;
  assign out_drive_n_out = oe_n_ff;
  assign upper_byte_sel_n_out = ~bytes_ff[1];
  assign lower_byte_sel_n_out = ~bytes_ff[0];
  assign mem_data_out = wdata_ff;
  assign mem_data_oe_out = {{8{lane_oe[1]}}, {8{lane_oe[0]}}};
  assign rsp_valid_out = rsp_ff;
  assign rsp_rdata_out = cap_data;
  assign retain_ok_out = ret_ff;
endmodule
`default_nettype wire

// [testbench/asmc_sram_model.sv]
`timescale 1ns/1ps
`default_nettype none
module asmc_sram_model #(
  parameter int ACC_NS = 70
) (
  input wire asmc_pkg::asmc_addr_t addr_in, // address
  input wire logic cs_n_in, // chip select
  input wire logic we_n_in, // write strobe
  input wire logic oe_n_in, // output drive
  input wire logic ub_n_in, // upper byte
  input wire logic lb_n_in, // lower byte
  input wire asmc_pkg::asmc_data_t wdata_in, // bus level
  output asmc_pkg::asmc_data_t rdata_out // device side of bus
);
  import asmc_pkg::*;
  logic [15:0] mem [0:131071];
  logic [1:0] wr_lanes = 2'b00;
  logic [1:0] cur;
  logic [1:0] ended;
  logic [1:0] drv;
  logic rd_sel;
  logic rd_ok;
  initial foreach (mem[i]) mem[i] = 16'h0000;
  assign rd_sel = !cs_n_in && we_n_in && !oe_n_in;
  assign drv = rd_sel ? ~{ub_n_in, lb_n_in} : 2'b00;
  // late data shows as inverted, never as a clean old value
  assign #(ACC_NS) rd_ok = rd_sel;
  always_comb begin
    // old data drops at once on an address move, stricter than the hold
    for (int l = 0; l < 2; l++)
      rdata_out[l*8 +: 8] = (drv[l] && rd_ok) ? mem[addr_in][l*8 +: 8] :
                            ~mem[addr_in][l*8 +: 8];
  end
  always @(cs_n_in, we_n_in, ub_n_in, lb_n_in) begin
    cur = (!cs_n_in && !we_n_in) ? ~{ub_n_in, lb_n_in} : 2'b00;
    // only lanes leaving the overlap store, so strobes settling in any
    // order at write start never store stale data or a stale address
    ended = wr_lanes & ~cur;
    if (ended[0]) mem[addr_in][7:0] = wdata_in[7:0];
    if (ended[1]) mem[addr_in][15:8] = wdata_in[15:8];
    wr_lanes = cur;
  end
endmodule
`default_nettype wire

// [testbench/asmc_host_sva.sv]
`timescale 1ns/1ps
`default_nettype none
module asmc_host_sva (
  input wire logic clk_sys_in, // clock
  input wire logic sys_rst_in, // reset
  input wire logic req_ready_out, // ready
  input wire logic rsp_valid_out, // read done
  input wire logic retain_ok_out, // retention ok
  input wire asmc_pkg::asmc_addr_t mem_addr_out, // address
  input wire logic chip_sel_n_out, // chip select
  input wire logic write_strobe_n_out, // write strobe
  input wire logic out_drive_n_out, // output drive
  input wire logic upper_byte_sel_n_out, // upper byte
  input wire logic lower_byte_sel_n_out, // lower byte
  input wire asmc_pkg::asmc_data_t mem_data_out, // write data
  input wire logic [15:0] mem_data_oe_out // drive enable
);
  import asmc_pkg::*;
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (sys_rst_in);
  logic ub, lb;
  assign ub = upper_byte_sel_n_out;
  assign lb = lower_byte_sel_n_out;
  AST_RESET_IDLE: assert property ($past(sys_rst_in) |-> chip_sel_n_out &&
    write_strobe_n_out && out_drive_n_out && mem_data_oe_out == 16'h0000)
    else $error("strobes active right after reset");
  AST_READ_FORM: assert property (!out_drive_n_out |-> write_strobe_n_out &&
    !chip_sel_n_out && !(ub && lb)) else $error("bad read pin state");
  AST_WRITE_FORM: assert property (!write_strobe_n_out |-> out_drive_n_out &&
    !chip_sel_n_out && mem_data_oe_out == {{8{!ub}}, {8{!lb}}})
    else $error("bad write pin state");
  AST_NO_FIGHT: assert property (!out_drive_n_out |=>
    (mem_data_oe_out == 16'h0000)[*4]) else $error("bus driven in turn");
  AST_WE_HOLD: assert property ($fell(write_strobe_n_out) |=>
    (!write_strobe_n_out && !chip_sel_n_out && $stable(mem_addr_out) &&
    $stable({ub, lb}))[*7]) else $error("write window too short");
  AST_DATA_SETUP: assert property ($rose(write_strobe_n_out) |->
    mem_data_out == $past(mem_data_out, 4)) else $error("data setup short");
  AST_READ_WAIT: assert property ($fell(out_drive_n_out) |->
    (!out_drive_n_out && !rsp_valid_out)[*8] ##1
    (!out_drive_n_out && !rsp_valid_out) ##[1:4] rsp_valid_out)
    else $error("read answer timing");
  AST_PDOWN: assert property ($rose(chip_sel_n_out) |->
    !req_ready_out[*8]) else $error("ready before power down");
  AST_RETAIN: assert property ($rose(retain_ok_out) |->
    $past(chip_sel_n_out) && chip_sel_n_out) else $error("retain while selected");
endmodule
`default_nettype wire

// [testbench/asmc_host_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module asmc_host_tb;
  import asmc_pkg::*;
  logic clk_sys_in, sys_rst_in, req_valid_in, req_write_in, retain_req_in;
  asmc_addr_t req_addr_in, mem_addr_out;
  asmc_data_t req_wdata_in, rsp_rdata_out, mem_data_in, mem_data_out, sram_q;
  logic [1:0] req_bytes_in;
  logic req_ready_out, rsp_valid_out, retain_ok_out, chip_sel_n_out;
  logic write_strobe_n_out, out_drive_n_out, upper_byte_sel_n_out;
  logic lower_byte_sel_n_out;
  logic [15:0] mem_data_oe_out;
  int miscompares = 0;
  int num_checks = 0;
  bit [31:0] seed = 89;
  logic [15:0] ref_mem [int];
  logic [15:0] last_rd = 16'h0000;
  bit [31:0] r;
  asmc_host DUT (.*);
  asmc_sram_model #(.ACC_NS(70)) sram (.addr_in(mem_addr_out),
    .cs_n_in(chip_sel_n_out), .we_n_in(write_strobe_n_out),
    .oe_n_in(out_drive_n_out), .ub_n_in(upper_byte_sel_n_out),
    .lb_n_in(lower_byte_sel_n_out), .wdata_in(mem_data_in),
    .rdata_out(sram_q));
  assign mem_data_in = (mem_data_oe_out & mem_data_out) |
                       (~mem_data_oe_out & sram_q);
  initial begin
    clk_sys_in = 1'b0;
    forever #4 clk_sys_in = ~clk_sys_in;
  end
  ////////////////////////////////////////////////////////////
  function automatic bit [31:0] rnd;
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic results;
    if (miscompares == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // one request, then watch 20 cycles for an answer
  task automatic op(input bit w, input asmc_addr_t a, input asmc_data_t d,
                    input logic [1:0] b);
    logic [15:0] exp, wv;
    logic got;
    int n;
    exp = last_rd;
    wv = ref_mem.exists(a) ? ref_mem[a] : 16'h0000;
    got = 1'b0;
    n = 0;
    req_valid_in = 1'b1;
    req_write_in = w;
    req_addr_in = a;
    req_wdata_in = d;
    req_bytes_in = b;
    while (req_ready_out !== 1'b1 && n < 60) begin
      @(negedge clk_sys_in);
      n++;
    end
    check(16'(n < 60), 16'h0001);
    @(negedge clk_sys_in);
    req_valid_in = 1'b0;
    for (int l = 0; l < 2; l++)
      if (b[l] && w) wv[l*8 +: 8] = d[l*8 +: 8];
      else if (b[l]) exp[l*8 +: 8] = wv[l*8 +: 8];
    ref_mem[a] = wv;
    repeat (20) begin
      got |= rsp_valid_out;
      if (rsp_valid_out === 1'b1) check(rsp_rdata_out, exp);
      @(negedge clk_sys_in);
    end
    check(16'(got), 16'(!w && b != 2'b00));
    if (!w) last_rd = exp;
  endtask
  initial begin
    sys_rst_in = 1'b1;
    req_valid_in = 1'b0;
    req_write_in = 1'b0;
    req_addr_in = '0;
    req_wdata_in = '0;
    req_bytes_in = 2'b00;
    retain_req_in = 1'b0;
    repeat (20) @(negedge clk_sys_in);
    sys_rst_in = 1'b0;
    op(1'b1, 17'h1ffff, 16'ha5c3, 2'b11);
    op(1'b0, 17'h1ffff, 16'h0000, 2'b01);
    op(1'b1, 17'h1ffff, 16'h0000, 2'b10);
    op(1'b0, 17'h1ffff, 16'h0000, 2'b11);
    repeat (60) begin
      r = rnd();
      op(r[0], {13'h0000, r[4:1]}, r[31:16], r[6:5]);
    end
    retain_req_in = 1'b1;
    // last read may still be in power down for six more cycles
    repeat (12) @(negedge clk_sys_in);
    check(16'(retain_ok_out), 16'h0001);
    check(16'({chip_sel_n_out, req_ready_out}), 16'h0002);
    retain_req_in = 1'b0;
    op(1'b0, 17'h1ffff, 16'h0000, 2'b11);
    results();
  end
  initial begin
    #300000;
    miscompares++;
    results();
  end
endmodule
bind asmc_host asmc_host_sva sva (.*);
`default_nettype wire
